// ==== verilog/scf_pkg.sv ====
package scf_pkg;
   // Opcodes and opcode groups.
   localparam logic [7:0] OP_CALL_BASE   = 8'h00;
   localparam logic [7:0] OP_CALL_LAST   = 8'h0F;
   localparam logic [7:0] OP_JUMP_BASE   = 8'h40;
   localparam logic [7:0] OP_JUMP_LAST   = 8'h5F;
   localparam logic [7:0] OP_JUMP_VIA_A  = 8'h1F;
   localparam logic [7:0] OP_ZERO_A      = 8'h2F;
   localparam logic [7:0] OP_ZERO_B      = 8'h24;
   localparam logic [7:0] OP_ZERO_X      = 8'h20;
   localparam logic [7:0] OP_MEM_DEC     = 8'h27;
   localparam logic [7:0] OP_X_DEC       = 8'h22;
   localparam logic [7:0] OP_SIGN_MODE   = 8'h3C;
   localparam logic [7:0] OP_ZFILL_MODE  = 8'h3B;
   localparam logic [7:0] OP_BUF_LOAD    = 8'h6C;
   localparam logic [7:0] OP_GET_BASE    = 8'h30;
   localparam logic [7:0] OP_GET_LAST    = 8'h37;
   // Widths and constants.
   localparam int         A_W            = 14;
   localparam int         PC_W           = 14;
   localparam int         RAM_W          = 12;
   localparam int         X_W            = 8;
   localparam int         STACK_DEPTH    = 3;
   localparam logic [3:0] BUF_FULL_COUNT = 4'h8;
   localparam logic [3:0] EXT_MAX_BITS   = 4'h4;
   localparam logic [PC_W-1:0]  PC_STEP  = 14'h0002;
   localparam logic [RAM_W-1:0] DEC_ADD  = 12'h0FF;
   localparam logic [X_W-1:0]   X_WRAP   = 8'hFF;
   // Bit-fetch sources.
   localparam logic [1:0] SRC_INT_ROM    = 2'h0;
   localparam logic [1:0] SRC_EXT_ROM    = 2'h1;
   localparam logic [1:0] SRC_RAM        = 2'h2;

   typedef enum logic [3:0] {
      SCF_IDLE  = 4'b0001,
      SCF_SHIFT = 4'b0010,
      SCF_FETCH = 4'b0100,
      SCF_LOAD  = 4'b1000
   } scf_state_e;
endpackage : scf_pkg

// ==== verilog/scf_serializer.sv ====
`timescale 1ns/100ps
// Serializer buffer: one data byte plus a count of unused bits.
module scf_serializer
   import scf_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Control
   input  wire logic       load,
   input  wire logic [7:0] load_data,
   input  wire logic       shift,
   // State
   output logic            out_bit,
   output logic [3:0]      count
);
   typedef struct packed {
      logic [7:0] data;
      logic [3:0] count;
   } scf_ser_s;

   scf_ser_s cur, next_cur;

   always_comb begin
      next_cur = cur;
      if (load) begin
         next_cur.data  = load_data;
         next_cur.count = BUF_FULL_COUNT;
      end else if (shift && cur.count != 4'h0) begin
         next_cur.data  = {1'b0, cur.data[7:1]};
         next_cur.count = cur.count - 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign out_bit = cur.data[0];
   assign count   = cur.count;

   chk_count_reload: assert property (@(posedge clock) disable iff (reset)
      load |=> count == BUF_FULL_COUNT)
      else $error("buffer count not reloaded");
endmodule : scf_serializer

// ==== verilog/scf_core.sv ====
`timescale 1ns/100ps
module scf_core
   import scf_pkg::*;
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // Instruction issue
   input  wire logic             op_valid,
   input  wire logic [7:0]       op_code,
   input  wire logic [7:0]       op_operand,
   input  wire logic             irq_entry,
   input  wire logic [PC_W-1:0]  irq_vector,
   input  wire logic [1:0]       fetch_source,
   // Memory read and RAM write
   output logic                  mem_read,
   output logic                  mem_read_ram,
   output logic [PC_W-1:0]       mem_addr,
   input  wire logic             mem_ready,
   input  wire logic [RAM_W-1:0] mem_data,
   output logic                  ram_write,
   output logic [X_W-1:0]        ram_addr,
   output logic [RAM_W-1:0]      ram_wdata,
   // Narrow operand load into A or B
   input  wire logic             narrow_load,
   input  wire logic             narrow_to_b,
   input  wire logic [RAM_W-1:0] narrow_data,
   input  wire logic [3:0]       narrow_width,
   // Core state
   output logic                  busy,
   output logic [PC_W-1:0]       pc,
   output logic [A_W-1:0]        acc,
   output logic [A_W-1:0]        b_reg,
   output logic [X_W-1:0]        x_reg,
   output logic                  status_flag,
   output logic                  sign_extend,
   output logic [PC_W-1:0]       speech_pointer,
   output logic [PC_W-1:0]       stack0
);
   typedef struct packed {
      scf_state_e        state;
      logic [PC_W-1:0]   pc;
      logic [A_W-1:0]    acc;
      logic [A_W-1:0]    b;
      logic [X_W-1:0]    x;
      logic              flag;
      logic              sext;
      logic [PC_W-1:0]   sptr;
      logic [PC_W-1:0]   stk0;
      logic [PC_W-1:0]   stk1;
      logic [PC_W-1:0]   stk2;
      logic [3:0]        left;
      logic              mrd;
      logic              mram;
      logic [PC_W-1:0]   maddr;
      logic              wr;
      logic [RAM_W-1:0]  wdata;
      logic              bsy;
   } scf_core_s;

   scf_core_s cur, next_cur;
   logic       ser_bit;
   logic [3:0] ser_count;
   logic       ser_shift;
   logic       ser_load;

   // Extends an operand of the given width to 14 bits per the current mode.
   function automatic logic [A_W-1:0] widen(input logic [RAM_W-1:0] d,
                                            input logic [3:0] w,
                                            input logic sx);
      logic [A_W-1:0] r;
      logic           top;
      r   = '0;
      top = d[w-4'h1];
      for (int i = 0; i < A_W; i++) begin
         if (i < int'(w)) begin
            r[i] = d[i];
         end else begin
            r[i] = sx & top;
         end
      end
      return r;
   endfunction : widen

   function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                     input logic [7:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction : in_range

   scf_serializer u_ser (
      .clock     (clock),
      .reset     (reset),
      .load      (ser_load),
      .load_data (mem_data[7:0]),
      .shift     (ser_shift),
      .out_bit   (ser_bit),
      .count     (ser_count)
   );

   assign ser_shift = (cur.state == SCF_SHIFT) && (cur.left != 4'h0) && (ser_count != 4'h0);
   // The byte stands on the data lines only in the cycle the memory answers, so the
   // buffer takes it at that very edge and holds a full count when shifting resumes.
   assign ser_load  = (cur.state == SCF_LOAD) && mem_ready;

   always_comb begin
      logic [RAM_W-1:0] dec_sum;
      logic [3:0]       n;
      dec_sum       = '0;
      n             = '0;
      next_cur      = cur;
      next_cur.wr     = 1'b0;
      case (cur.state)
         SCF_IDLE: begin
            if (irq_entry) begin
               next_cur.stk2 = cur.stk1;
               next_cur.stk1 = cur.stk0;
               next_cur.stk0 = cur.pc;
               next_cur.pc   = irq_vector;
            end else if (narrow_load) begin
               if (narrow_to_b) begin
                  next_cur.b   = widen(narrow_data, narrow_width, cur.sext);
               end else begin
                  next_cur.acc = widen(narrow_data, narrow_width, cur.sext);
               end
            end else if (op_valid) begin
               next_cur.flag = 1'b1;
               next_cur.pc   = cur.pc + PC_STEP;
               if (in_range(op_code, OP_JUMP_BASE, OP_JUMP_LAST)) begin
                  if (cur.flag) begin
                     next_cur.pc = {1'b0, op_code[4:0], op_operand};
                  end
               end else if (in_range(op_code, OP_CALL_BASE, OP_CALL_LAST)) begin
                  if (cur.flag) begin
                     next_cur.stk2 = cur.stk1;
                     next_cur.stk1 = cur.stk0;
                     next_cur.stk0 = cur.pc;
                     next_cur.pc   = {2'b00, op_code[3:0], op_operand};
                  end
               end else if (op_code == OP_JUMP_VIA_A) begin
                  next_cur.pc = cur.acc;
               end else if (op_code == OP_ZERO_A) begin
                  next_cur.acc = '0;
               end else if (op_code == OP_ZERO_B) begin
                  next_cur.b = '0;
               end else if (op_code == OP_ZERO_X) begin
                  next_cur.x = '0;
               end else if (op_code == OP_X_DEC) begin
                  next_cur.x    = cur.x - 8'h01;
                  next_cur.flag = (cur.x == 8'h00);
               end else if (op_code == OP_SIGN_MODE) begin
                  next_cur.sext = 1'b1;
               end else if (op_code == OP_ZFILL_MODE) begin
                  next_cur.sext = 1'b0;
               end else if (op_code == OP_MEM_DEC) begin
                  next_cur.mrd   = 1'b1;
                  next_cur.mram  = 1'b1;
                  next_cur.maddr = {6'h00, cur.x};
                  next_cur.left  = 4'h0;
                  next_cur.state = SCF_FETCH;
               end else if (op_code == OP_BUF_LOAD) begin
                  next_cur.sptr  = cur.acc;
                  next_cur.mrd   = 1'b1;
                  next_cur.mram  = 1'b0;
                  next_cur.maddr = cur.acc;
                  next_cur.left  = 4'h0;
                  next_cur.state = SCF_LOAD;
               end else if (in_range(op_code, OP_GET_BASE, OP_GET_LAST)) begin
                  n = {1'b0, op_code[2:0]} + 4'h1;
                  if (fetch_source == SRC_EXT_ROM && n > EXT_MAX_BITS) begin
                     n = EXT_MAX_BITS;
                  end
                  next_cur.left  = n;
                  next_cur.state = SCF_SHIFT;
               end
            end
         end
         SCF_SHIFT: begin
            if (cur.left == 4'h0) begin
               next_cur.flag  = (ser_count == 4'h0);
               next_cur.state = SCF_IDLE;
            end else if (ser_count == 4'h0) begin
               next_cur.mrd   = 1'b1;
               next_cur.mram  = (fetch_source == SRC_RAM);
               next_cur.maddr = (fetch_source == SRC_RAM) ? {6'h00, cur.x} : cur.sptr;
               next_cur.state = SCF_LOAD;
            end else begin
               next_cur.acc  = {cur.acc[A_W-2:0], ser_bit};
               next_cur.left = cur.left - 4'h1;
            end
         end
         SCF_LOAD: begin
            if (mem_ready) begin
               next_cur.mrd    = 1'b0;
               if (!cur.mram) begin
                  next_cur.sptr = cur.sptr + 14'h0001;
               end
               next_cur.state = (cur.left == 4'h0) ? SCF_IDLE : SCF_SHIFT;
            end
         end
         SCF_FETCH: begin
            if (mem_ready) begin
               dec_sum        = mem_data + DEC_ADD;
               next_cur.mrd   = 1'b0;
               next_cur.wr    = 1'b1;
               next_cur.wdata = dec_sum;
               next_cur.flag  = (mem_data[7:0] == 8'h00);
               next_cur.state = SCF_IDLE;
            end
         end
         default: begin
            next_cur.state = SCF_IDLE;
         end
      endcase
      next_cur.bsy = (next_cur.state != SCF_IDLE);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         cur       <= '0;
         cur.state <= SCF_IDLE;
         cur.flag  <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign busy           = cur.bsy;
   assign pc             = cur.pc;
   assign acc            = cur.acc;
   assign b_reg          = cur.b;
   assign x_reg          = cur.x;
   assign status_flag    = cur.flag;
   assign sign_extend    = cur.sext;
   assign speech_pointer = cur.sptr;
   assign stack0         = cur.stk0;
   assign mem_read       = cur.mrd;
   assign mem_read_ram   = cur.mram;
   assign mem_addr       = cur.maddr;
   assign ram_write      = cur.wr;
   assign ram_addr       = cur.x;
   assign ram_wdata      = cur.wdata;

   logic idle_op;
   assign idle_op = op_valid && !irq_entry && !narrow_load && cur.state == SCF_IDLE;

   chk_jump_taken: assert property (@(posedge clock) disable iff (reset)
      idle_op && in_range(op_code, OP_JUMP_BASE, OP_JUMP_LAST) && status_flag
      |=> pc == {1'b0, $past(op_code[4:0]), $past(op_operand)} && status_flag)
      else $error("jump target wrong");
   chk_jump_skip: assert property (@(posedge clock) disable iff (reset)
      idle_op && in_range(op_code, OP_JUMP_BASE, OP_JUMP_LAST) && !status_flag
      |=> pc == $past(pc) + PC_STEP && status_flag)
      else $error("untaken jump wrong");
   chk_via_acc: assert property (@(posedge clock) disable iff (reset)
      idle_op && op_code == OP_JUMP_VIA_A |=> pc == $past(acc))
      else $error("indirect jump wrong");
   chk_call_push: assert property (@(posedge clock) disable iff (reset)
      idle_op && in_range(op_code, OP_CALL_BASE, OP_CALL_LAST) && status_flag
      |=> stack0 == $past(pc) && pc[13:12] == 2'b00)
      else $error("call push wrong");
   chk_zero_regs: assert property (@(posedge clock) disable iff (reset)
      idle_op && op_code == OP_ZERO_A |=> acc == '0 && status_flag)
      else $error("zero A failed");
   chk_zero_x: assert property (@(posedge clock) disable iff (reset)
      idle_op && op_code == OP_ZERO_X |=> x_reg == 8'h00 && status_flag)
      else $error("zero X failed");
   chk_x_dec: assert property (@(posedge clock) disable iff (reset)
      idle_op && op_code == OP_X_DEC
      |=> x_reg == $past(x_reg) - 8'h01 && status_flag == ($past(x_reg) == 8'h00))
      else $error("X decrement wrong");
   chk_mode_set: assert property (@(posedge clock) disable iff (reset)
      idle_op && op_code == OP_SIGN_MODE |=> sign_extend ##0 status_flag)
      else $error("sign mode not set");
   chk_mem_dec: assert property (@(posedge clock) disable iff (reset)
      cur.state == SCF_FETCH && mem_ready
      |=> ram_write && ram_wdata == $past(mem_data) + DEC_ADD)
      else $error("memory decrement wrong");
   chk_call_skip: assert property (@(posedge clock) disable iff (reset)
      idle_op && in_range(op_code, OP_CALL_BASE, OP_CALL_LAST) && !status_flag
      |=> pc == $past(pc) + PC_STEP && stack0 == $past(stack0) && status_flag)
      else $error("untaken call wrong");
   chk_stack_push: assert property (@(posedge clock) disable iff (reset)
      cur.state == SCF_IDLE && irq_entry
      |=> pc == $past(irq_vector) && stack0 == $past(pc)
          && cur.stk1 == $past(cur.stk0) && cur.stk2 == $past(cur.stk1))
      else $error("stack push wrong");
   chk_zero_b: assert property (@(posedge clock) disable iff (reset)
      idle_op && op_code == OP_ZERO_B |=> b_reg == '0 && status_flag)
      else $error("zero B failed");
   chk_mem_flag: assert property (@(posedge clock) disable iff (reset)
      cur.state == SCF_FETCH && mem_ready
      |=> status_flag == ($past(mem_data[7:0]) == 8'h00) && !busy)
      else $error("memory decrement flag wrong");
   chk_ext_limit: assert property (@(posedge clock) disable iff (reset)
      idle_op && in_range(op_code, OP_GET_BASE, OP_GET_LAST)
      && fetch_source == SRC_EXT_ROM
      |=> cur.left != 4'h0 && cur.left <= EXT_MAX_BITS)
      else $error("external fetch count wrong");
   chk_shift_in: assert property (@(posedge clock) disable iff (reset)
      ser_shift |=> acc[0] == $past(ser_bit) && acc[A_W-1:1] == $past(acc[A_W-2:0]))
      else $error("fetch shift wrong");
   chk_refill_request: assert property (@(posedge clock) disable iff (reset)
      cur.state == SCF_SHIFT && cur.left != 4'h0 && ser_count == 4'h0
      |=> mem_read && busy)
      else $error("buffer refill not requested");
   chk_fetch_flag: assert property (@(posedge clock) disable iff (reset)
      cur.state == SCF_SHIFT && cur.left == 4'h0
      |=> status_flag == ($past(ser_count) == 4'h0) && !busy)
      else $error("fetch flag wrong");
   chk_zfill_mode: assert property (@(posedge clock) disable iff (reset)
      idle_op && op_code == OP_ZFILL_MODE |=> !sign_extend && status_flag)
      else $error("zero-fill mode not set");
   chk_buf_load: assert property (@(posedge clock) disable iff (reset)
      idle_op && op_code == OP_BUF_LOAD
      |=> speech_pointer == $past(acc) && mem_read && mem_addr == $past(acc))
      else $error("buffer load start wrong");
   chk_rom_step: assert property (@(posedge clock) disable iff (reset)
      cur.state == SCF_LOAD && mem_ready && !cur.mram
      |=> speech_pointer == $past(speech_pointer) + 14'h0001)
      else $error("pointer not stepped");
   chk_ram_no_step: assert property (@(posedge clock) disable iff (reset)
      cur.state == SCF_LOAD && mem_ready && cur.mram |=> $stable(speech_pointer))
      else $error("pointer stepped on RAM refill");
endmodule : scf_core

// ==== testbench/scf_mem_model.sv ====
`timescale 1ns/100ps
// Program and speech memory: ROM bytes follow from the address, RAM is an array.
module scf_mem_model
   import scf_pkg::*;
(
   // Clock and pacing
   input  wire logic             clock,
   input  wire logic             slow,
   // Read side
   input  wire logic             mem_read,
   input  wire logic             mem_read_ram,
   input  wire logic [PC_W-1:0]  mem_addr,
   output logic                  mem_ready,
   output logic [RAM_W-1:0]      mem_data,
   // Write side
   input  wire logic             ram_write,
   input  wire logic [X_W-1:0]   ram_addr,
   input  wire logic [RAM_W-1:0] ram_wdata
);
   logic [RAM_W-1:0] ram [0:255];
   logic             ready_q  = 1'b0;
   logic [RAM_W-1:0] data_q   = 12'h000;
   int               wait_cnt = 0;
   int               tick     = 0;
   assign mem_ready = ready_q;
   assign mem_data  = data_q;
   // Outside an answer the data lines change every cycle, so a stale value never looks valid.
   always @(posedge clock) begin
      tick <= tick + 1;
      if (mem_read && !ready_q && wait_cnt >= (slow ? 3 : 0)) begin
         ready_q  <= 1'b1;
         data_q   <= mem_read_ram ? ram[mem_addr[7:0]] : {4'hC, mem_addr[7:0] ^ 8'h5A};
         wait_cnt <= 0;
      end else begin
         ready_q  <= 1'b0;
         data_q   <= tick[11:0] ^ 12'hA5A;
         wait_cnt <= mem_read ? wait_cnt + 1 : 0;
      end
      if (ram_write) begin
         ram[ram_addr] <= ram_wdata;
      end
   end
endmodule : scf_mem_model

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   import scf_pkg::*;
   logic             clock        = 1'b0;
   logic             reset        = 1'b1;
   logic             op_valid     = 1'b0;
   logic [7:0]       op_code      = 8'h00;
   logic [7:0]       op_operand   = 8'h00;
   logic             irq_entry    = 1'b0;
   logic [PC_W-1:0]  irq_vector   = 14'h0000;
   logic [1:0]       fetch_source = 2'h0;
   logic             narrow_load  = 1'b0;
   logic             narrow_to_b  = 1'b0;
   logic [RAM_W-1:0] narrow_data  = 12'h000;
   logic [3:0]       narrow_width = 4'h0;
   logic             slow         = 1'b0;
   logic             mem_read, mem_read_ram, mem_ready, ram_write, busy, status_flag, sign_extend;
   logic [PC_W-1:0]  mem_addr, pc, speech_pointer, stack0, tb_ptr, pc_was;
   logic [RAM_W-1:0] mem_data, ram_wdata;
   logic [X_W-1:0]   ram_addr, x_reg;
   logic [A_W-1:0]   acc, b_reg, exp_acc;
   logic [7:0]       tb_byte;
   logic [3:0]       tb_cnt;
   int               error_cnt    = 0;
   int               compares     = 0;

   always #25 clock = ~clock;

   scf_core i_scf_core (.clock, .reset, .op_valid, .op_code, .op_operand, .irq_entry,
      .irq_vector, .fetch_source, .mem_read, .mem_read_ram, .mem_addr, .mem_ready, .mem_data,
      .ram_write, .ram_addr, .ram_wdata, .narrow_load, .narrow_to_b, .narrow_data,
      .narrow_width, .busy, .pc, .acc, .b_reg, .x_reg, .status_flag, .sign_extend,
      .speech_pointer, .stack0);
   scf_mem_model i_scf_mem_model (.clock, .slow, .mem_read, .mem_read_ram, .mem_addr,
      .mem_ready, .mem_data, .ram_write, .ram_addr, .ram_wdata);

   task automatic close_out();
      $display("Counts: %0d compares, %0d errors", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [A_W-1:0] got, input logic [A_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask : check

   task automatic issue(input logic [7:0] code, input logic [7:0] opnd);
      int n;
      n = 0;
      @(posedge clock);
      op_valid   <= 1'b1;
      op_code    <= code;
      op_operand <= opnd;
      @(posedge clock);
      op_valid <= 1'b0;
      #1;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 200) check(busy, 1'b0);
   endtask : issue

   task automatic nload(input logic to_b, input logic [RAM_W-1:0] d, input logic [3:0] w);
      @(posedge clock);
      narrow_load  <= 1'b1;
      narrow_to_b  <= to_b;
      narrow_data  <= d;
      narrow_width <= w;
      @(posedge clock);
      narrow_load <= 1'b0;
      #1;
   endtask : nload

   // Reference serializer: bit counts, refills and pointer steps worked out independently.
   task automatic get_exp(input int n, input logic [1:0] src);
      for (int i = 0; i < n; i++) begin
         if (tb_cnt == 4'h0) begin
            tb_byte = (src == SRC_RAM) ? i_scf_mem_model.ram[x_reg][7:0] : tb_ptr[7:0] ^ 8'h5A;
            tb_cnt  = BUF_FULL_COUNT;
            if (src != SRC_RAM) tb_ptr++;
         end
         exp_acc = {exp_acc[A_W-2:0], tb_byte[0]};
         tb_byte = tb_byte >> 1;
         tb_cnt--;
      end
   endtask : get_exp

   task automatic t_flow();
      issue(8'h45, 8'h12);
      check(pc, 14'h0512);
      issue(OP_X_DEC, 8'h00);
      check(x_reg, X_WRAP);
      check(status_flag, 1'b1);
      issue(OP_X_DEC, 8'h00);
      check(x_reg, 8'hFE);
      check(status_flag, 1'b0);
      pc_was = pc;
      issue(8'h03, 8'h45);
      check(pc, pc_was + PC_STEP);
      check(status_flag, 1'b1);
      pc_was = pc;
      issue(OP_CALL_LAST, 8'h45);
      check(pc, 14'h0F45);
      check(stack0, pc_was);
      issue(OP_X_DEC, 8'h00);
      pc_was = pc;
      issue(OP_JUMP_LAST, 8'hFF);
      check(pc, pc_was + PC_STEP);
      check(status_flag, 1'b1);
      pc_was = pc;
      @(posedge clock);
      irq_entry  <= 1'b1;
      irq_vector <= 14'h2ABC;
      @(posedge clock);
      irq_entry <= 1'b0;
      #1;
      check(pc, 14'h2ABC);
      check(stack0, pc_was);
      $display("test flow done");
   endtask : t_flow

   task automatic t_modes();
      nload(1'b0, 12'h800, 4'hC);
      check(acc, 14'h0800);
      issue(OP_SIGN_MODE, 8'h00);
      check(sign_extend, 1'b1);
      check(status_flag, 1'b1);
      nload(1'b0, 12'h800, 4'hC);
      check(acc, 14'h3800);
      nload(1'b1, 12'h080, 4'h8);
      check(b_reg, 14'h3F80);
      issue(OP_X_DEC, 8'h00);
      issue(OP_JUMP_VIA_A, 8'h00);
      check(pc, 14'h3800);
      issue(OP_ZERO_A, 8'h00);
      check(acc, 14'h0000);
      issue(OP_ZERO_B, 8'h00);
      check(b_reg, 14'h0000);
      issue(OP_X_DEC, 8'h00);
      issue(OP_ZERO_X, 8'h00);
      check(x_reg, 8'h00);
      check(status_flag, 1'b1);
      issue(OP_ZFILL_MODE, 8'h00);
      check(sign_extend, 1'b0);
      check(status_flag, 1'b1);
      $display("test modes done");
   endtask : t_modes

   task automatic t_memdec();
      i_scf_mem_model.ram[0] = 12'h100;
      issue(OP_MEM_DEC, 8'h00);
      check(status_flag, 1'b1);
      @(posedge clock);
      #1;
      check(i_scf_mem_model.ram[0], 12'h1FF);
      slow = 1'b1;
      i_scf_mem_model.ram[0] = 12'h234;
      issue(OP_MEM_DEC, 8'h00);
      check(status_flag, 1'b0);
      @(posedge clock);
      #1;
      check(i_scf_mem_model.ram[0], 12'h333);
      $display("test memdec done");
   endtask : t_memdec

   task automatic t_fetch();
      nload(1'b0, 12'h010, 4'hC);
      issue(OP_BUF_LOAD, 8'h00);
      check(speech_pointer, 14'h0011);
      tb_ptr = 14'h0010;
      tb_cnt = 4'h0;
      issue(OP_ZERO_A, 8'h00);
      exp_acc = 14'h0000;
      issue(8'h34, 8'h00);
      get_exp(5, SRC_INT_ROM);
      check(acc, exp_acc);
      check(status_flag, 1'b0);
      issue(8'h34, 8'h00);
      get_exp(5, SRC_INT_ROM);
      check(acc, exp_acc);
      check(speech_pointer, tb_ptr);
      issue(8'h35, 8'h00);
      get_exp(6, SRC_INT_ROM);
      check(acc, exp_acc);
      check(status_flag, 1'b1);
      @(posedge clock);
      fetch_source <= SRC_RAM;
      i_scf_mem_model.ram[0] = 12'h0A5;
      issue(8'h30, 8'h00);
      get_exp(1, SRC_RAM);
      check(acc, exp_acc);
      check(speech_pointer, tb_ptr);
      check(status_flag, 1'b0);
      @(posedge clock);
      fetch_source <= SRC_EXT_ROM;
      issue(8'h37, 8'h00);
      get_exp(4, SRC_EXT_ROM);
      check(acc, exp_acc);
      check(speech_pointer, tb_ptr);
      check(status_flag, 1'b0);
      slow = 1'b0;
      $display("test fetch done");
   endtask : t_fetch

   initial begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      #1;
      check(pc, 14'h0000);
      check(status_flag, 1'b1);
      check(sign_extend, 1'b0);
      $display("test reset done");
      t_flow();
      t_modes();
      t_memdec();
      t_fetch();
      close_out();
   end

   initial begin
      #(50 * 20000);
      error_cnt++;
      close_out();
   end
endmodule : testbench
